// *** rtl/dcc_pkg.sv ***
// Constants shared by the dual comparator control block.
// Assumes one 10 MHz system clock and a byte-wide register port.
package dcc_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] DCC_OFS_TIMER_LINK = 8'h97;
  localparam logic [7:0] DCC_OFS_CONFIG = 8'h9C;
  localparam logic [7:0] DCC_OFS_FLAGS = 8'h0D;
  localparam logic [7:0] DCC_OFS_ENABLES = 8'h8D;
  localparam logic [7:0] DCC_OFS_IRQ_CTRL = 8'h0B;
  localparam logic [7:0] DCC_OFS_PORT_DIR = 8'h85;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int DCC_BIT_B_RESULT = 7;
  localparam int DCC_BIT_A_RESULT = 6;
  localparam int DCC_BIT_B_POL = 5;
  localparam int DCC_BIT_A_POL = 4;
  localparam int DCC_BIT_SWITCH = 3;
  localparam int DCC_BIT_GATE_SEL = 1;
  localparam int DCC_BIT_SYNC = 0;
  localparam int DCC_BIT_B_FLAG = 6;
  localparam int DCC_BIT_A_FLAG = 5;
  localparam int DCC_BIT_GIE = 7;
  localparam int DCC_BIT_PERIPHERAL_IRQ_ENABLE = 6;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] DCC_RST_CONFIG = 8'h00;
  localparam logic [1:0] DCC_RST_TIMER_LINK = 2'h2;
  localparam logic [1:0] DCC_RST_FLAGS = 2'h0;
  localparam logic [7:0] DCC_RST_PORT_DIR = 8'hFF;
  // ----------------------------------------
  // Modes
  // ----------------------------------------
  localparam logic [2:0] DCC_MODE_RESET = 3'h0;
  localparam logic [2:0] DCC_MODE_ONE_SWITCHED = 3'h1;
  localparam logic [2:0] DCC_MODE_TWO_SWITCHED = 3'h2;
  localparam logic [2:0] DCC_MODE_OFF = 3'h7;
endpackage

// *** rtl/dcc_sync2.sv ***
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes inputs may change at any time relative to the clock.
`timescale 1ns/1ps
module dcc_sync2 #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Data
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;
endmodule

// *** rtl/dcc_gate_latch.sv ***
// Latches comparator B on the falling edge of the prescaled timer clock.
// Timer clock is a synchronised level; the timer counts on its rising edge.
`timescale 1ns/1ps
module dcc_gate_latch (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Controls
  input wire logic i_sync_en,
  input wire logic i_timer_clk,
  input wire logic i_cmp_b,
  // Result
  output logic o_cmp_b_gate
);
  logic tclk_d_r;
  logic held_r;
  logic fall;

  assign fall = tclk_d_r & ~i_timer_clk;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tclk_d_r <= 1'b0;
      held_r <= 1'b0;
    end else begin
      tclk_d_r <= i_timer_clk;
      if (fall) begin
        held_r <= i_cmp_b;
      end
    end
  end

  assign o_cmp_b_gate = i_sync_en ? held_r : i_cmp_b;
endmodule

// *** rtl/dcc_top.sv ***
// Digital control around two analog comparators: config, routing, gating, flags.
// Assumes analog cores deliver raw comparison levels; register port is byte wide.
//
// Overview of operation
// - Raw result high when plus exceeds minus
// - Polarity bit complements reported, routed result
// - Results shown at config bits 7, 6
// - Three-bit mode field picks eight configurations
// - Mode 010 switch selects lines 3/2 else 0/1
// - Mode 001 switch selects line 3 else 0
// - Analog pins lose digital input, pullup, change
// - Routing mode drives lines 4,5 with unsynchronised, polarity-applied results
// - Direction bits still enable lines 4,5 outputs
// - Gate source bit picks pin or comparator B
// - Sync bit latches B on timer falling edge
// - Timer counts rising, latch changes falling
// - Flag set when result differs from latch
// - Flags cleared by writing 0, set by 1
// - Request needs all three enables; flags regardless
// - Config access relatches; mismatch keeps setting flag
// - Change during config read still sets flag
// - Reset returns registers, mode field to 000
// - Comparators run in sleep; irq wakes device
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module dcc_top (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RESET_N,
  // Register port
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  // Analog comparator cores
  input wire logic I_CMP_A_RAW,
  input wire logic I_CMP_B_RAW,
  output logic [2:0] O_CMP_MODE,
  output logic O_CMP_A_MINUS_SEL,
  output logic O_CMP_B_MINUS_SEL,
  output logic [3:0] O_ANALOG_PINS,
  // Port A lines 4 and 5
  input wire logic I_LINE4_DATA,
  input wire logic I_LINE5_DATA,
  output logic O_LINE4_OUT,
  output logic O_LINE5_OUT,
  output logic O_LINE4_OE_N,
  output logic O_LINE5_OE_N,
  // Companion timer
  input wire logic I_TIMER_CLK,
  input wire logic I_GATE_PIN,
  output logic O_TIMER_GATE,
  // Interrupt and sleep
  input wire logic I_SLEEP,
  output logic O_IRQ,
  output logic O_WAKE
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] config_r;
  logic [1:0] link_r;
  logic [1:0] flags_r;
  logic [1:0] enables_r;
  logic [1:0] irq_ctrl_r;
  logic [7:0] port_dir_r;
  logic [1:0] seen_r;
  logic [7:0] rdata_r;
  logic [1:0] flags_nxt;

  // ----------------------------------------
  // Synchronised inputs
  // ----------------------------------------
  logic [1:0] raw_sync;
  logic [1:0] tmr_sync;
  logic [1:0] cur;
  logic cmp_on;

  dcc_sync2 #(.WIDTH(2)) u_sync_cmp (
    .i_clk(I_MCLK),
    .i_reset_n(I_RESET_N),
    .i_async({I_CMP_B_RAW, I_CMP_A_RAW}),
    .o_sync(raw_sync)
  );

  dcc_sync2 #(.WIDTH(2)) u_sync_tmr (
    .i_clk(I_MCLK),
    .i_reset_n(I_RESET_N),
    .i_async({I_GATE_PIN, I_TIMER_CLK}),
    .o_sync(tmr_sync)
  );

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic [2:0] mode;
  logic sel_link;
  logic sel_cfg;
  logic sel_flags;
  logic sel_en;
  logic sel_ictl;
  logic sel_dir;
  logic cfg_touch;
  logic routed;
  logic pol_a;
  logic pol_b;

  assign mode = config_r[2:0];
  assign pol_a = config_r[dcc_pkg::DCC_BIT_A_POL];
  assign pol_b = config_r[dcc_pkg::DCC_BIT_B_POL];
  assign cmp_on = (mode != dcc_pkg::DCC_MODE_RESET) && (mode != dcc_pkg::DCC_MODE_OFF);
  assign cur = cmp_on ? (raw_sync ^ {pol_b, pol_a}) : 2'h0;
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    addr_hit = addr == ofs;
  endfunction

  assign sel_link = addr_hit(I_ADDR, dcc_pkg::DCC_OFS_TIMER_LINK);
  assign sel_cfg = addr_hit(I_ADDR, dcc_pkg::DCC_OFS_CONFIG);
  assign sel_flags = addr_hit(I_ADDR, dcc_pkg::DCC_OFS_FLAGS);
  assign sel_en = addr_hit(I_ADDR, dcc_pkg::DCC_OFS_ENABLES);
  assign sel_ictl = addr_hit(I_ADDR, dcc_pkg::DCC_OFS_IRQ_CTRL);
  assign sel_dir = addr_hit(I_ADDR, dcc_pkg::DCC_OFS_PORT_DIR);
  assign cfg_touch = sel_cfg && (I_RD || I_WR);

  // ----------------------------------------
  // Input switching and analog pins
  // ----------------------------------------
  assign O_CMP_MODE = mode;
  // Minus-input select: 1 picks lines 3/2, 0 picks lines 0/1
  assign O_CMP_A_MINUS_SEL = ((mode == dcc_pkg::DCC_MODE_TWO_SWITCHED)
    || (mode == dcc_pkg::DCC_MODE_ONE_SWITCHED)) && config_r[dcc_pkg::DCC_BIT_SWITCH];
  assign O_CMP_B_MINUS_SEL = (mode == dcc_pkg::DCC_MODE_TWO_SWITCHED)
    && config_r[dcc_pkg::DCC_BIT_SWITCH];
  // Lines 0..3 analog (digital path, pull-up, change detect off) unless off mode
  assign O_ANALOG_PINS = (mode == dcc_pkg::DCC_MODE_OFF) ? 4'h0 : 4'hF;

  // ----------------------------------------
  // Output routing to lines 4 and 5
  // ----------------------------------------
  // Output routing mode chosen as 110 (routed outputs)
  assign routed = mode == 3'h6;
  assign O_LINE4_OUT = routed ? (I_CMP_A_RAW ^ pol_a) : I_LINE4_DATA;
  assign O_LINE5_OUT = routed ? (I_CMP_B_RAW ^ pol_b) : I_LINE5_DATA;
  assign O_LINE4_OE_N = port_dir_r[4];
  assign O_LINE5_OE_N = port_dir_r[5];

  // ----------------------------------------
  // Timer gate
  // ----------------------------------------
  logic b_gate;

  dcc_gate_latch u_gate (
    .i_clk(I_MCLK),
    .i_reset_n(I_RESET_N),
    .i_sync_en(link_r[dcc_pkg::DCC_BIT_SYNC]),
    .i_timer_clk(tmr_sync[0]),
    .i_cmp_b(cur[1]),
    .o_cmp_b_gate(b_gate)
  );

  assign O_TIMER_GATE = link_r[dcc_pkg::DCC_BIT_GATE_SEL] ? tmr_sync[1] : b_gate;

  // ----------------------------------------
  // Change flags
  // ----------------------------------------
  logic [1:0] mismatch;
  logic [1:0] flag_wr;

  assign mismatch = cur ^ seen_r;
  assign flag_wr = {I_WDATA[dcc_pkg::DCC_BIT_B_FLAG], I_WDATA[dcc_pkg::DCC_BIT_A_FLAG]};

  always_comb begin
    flags_nxt = flags_r;
    if (I_WR && sel_flags) begin
      flags_nxt = flag_wr;
    end
    flags_nxt = flags_nxt | mismatch;
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      config_r <= dcc_pkg::DCC_RST_CONFIG;
      link_r <= dcc_pkg::DCC_RST_TIMER_LINK;
      flags_r <= dcc_pkg::DCC_RST_FLAGS;
      enables_r <= 2'h0;
      irq_ctrl_r <= 2'h0;
      port_dir_r <= dcc_pkg::DCC_RST_PORT_DIR;
      seen_r <= 2'h0;
    end else begin
      if (I_WR && sel_cfg) begin
        config_r[5:0] <= I_WDATA[5:0];
      end
      if (I_WR && sel_link) begin
        link_r <= I_WDATA[1:0];
      end
      if (I_WR && sel_en) begin
        enables_r <= {I_WDATA[dcc_pkg::DCC_BIT_B_FLAG], I_WDATA[dcc_pkg::DCC_BIT_A_FLAG]};
      end
      if (I_WR && sel_ictl) begin
        irq_ctrl_r <= {I_WDATA[dcc_pkg::DCC_BIT_GIE], I_WDATA[dcc_pkg::DCC_BIT_PERIPHERAL_IRQ_ENABLE]};
      end
      if (I_WR && sel_dir) begin
        port_dir_r <= I_WDATA;
      end
      if (cfg_touch) begin
        seen_r <= cur;
      end
      flags_r <= flags_nxt;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [7:0] rd_mux;

  assign rd_mux = sel_cfg ? {cur, config_r[5:0]}
    : sel_link ? {6'h00, link_r}
    : sel_flags ? {1'b0, flags_r, 5'h00}
    : sel_en ? {1'b0, enables_r, 5'h00}
    : sel_ictl ? {irq_ctrl_r, 6'h00}
    : sel_dir ? port_dir_r
    : 8'h00;

  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= I_RD ? rd_mux : 8'h00;
    end
  end

  assign O_RDATA = rdata_r;

  // ----------------------------------------
  // Interrupt request and wake
  // ----------------------------------------
  logic any_req;

  assign any_req = |(flags_r & enables_r) && irq_ctrl_r[0];
  assign O_IRQ = any_req && irq_ctrl_r[1];
  assign O_WAKE = I_SLEEP && any_req;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_FLAG_ON_MISMATCH: assert property (
    @(posedge I_MCLK) disable iff (!I_RESET_N)
    (mismatch[0]) |=> flags_r[0]
  ) else $error("flag A not set on mismatch");

  AST_CLEAR_BY_ZERO: assert property (
    @(posedge I_MCLK) disable iff (!I_RESET_N)
    (I_WR && sel_flags && !flag_wr[1] && !mismatch[1]) |=> !flags_r[1]
  ) else $error("flag B not cleared by zero write");

  AST_SET_BY_ONE: assert property (
    @(posedge I_MCLK) disable iff (!I_RESET_N)
    (I_WR && sel_flags && flag_wr[0]) |=> flags_r[0]
  ) else $error("flag A not set by one write");

  AST_IRQ_ENABLES: assert property (
    @(posedge I_MCLK) disable iff (!I_RESET_N)
    O_IRQ |-> (irq_ctrl_r == 2'h3 && (flags_r & enables_r) != 2'h0)
  ) else $error("interrupt without all enables");

  AST_RELATCH: assert property (
    @(posedge I_MCLK) disable iff (!I_RESET_N)
    cfg_touch |=> (seen_r == $past(cur))
  ) else $error("latch not updated on config access");

  AST_STATUS_READ: assert property (
    @(posedge I_MCLK) disable iff (!I_RESET_N)
    (I_RD && sel_cfg) |=> (O_RDATA[7:6] == $past(cur))
  ) else $error("status bits wrong on read");

  AST_GATE_SOURCE: assert property (
    @(posedge I_MCLK) disable iff (!I_RESET_N)
    link_r[dcc_pkg::DCC_BIT_GATE_SEL] |-> (O_TIMER_GATE == tmr_sync[1])
  ) else $error("gate not from pin");

  AST_SYNC_HOLD: assert property (
    @(posedge I_MCLK) disable iff (!I_RESET_N)
    (link_r == 2'h1 && $past(link_r) == 2'h1
      && !($past(tmr_sync[0], 2) && !$past(tmr_sync[0]))) |-> $stable(O_TIMER_GATE)
  ) else $error("synced gate moved off falling edge");

  AST_OE_DIR: assert property (
    @(posedge I_MCLK) disable iff (!I_RESET_N)
    (I_WR && sel_dir) |=> (O_LINE4_OE_N == $past(I_WDATA[4])
      && O_LINE5_OE_N == $past(I_WDATA[5]))
  ) else $error("output enable not from direction bits");

  AST_FLAG_B_ON_MISMATCH: assert property (
    @(posedge I_MCLK) disable iff (!I_RESET_N)
    (mismatch[1]) |=> flags_r[1]
  ) else $error("flag B not set on mismatch");

  AST_CLEAR_A_BY_ZERO: assert property (
    @(posedge I_MCLK) disable iff (!I_RESET_N)
    (I_WR && sel_flags && !flag_wr[0] && !mismatch[0]) |=> !flags_r[0]
  ) else $error("flag A not cleared by zero write");

  AST_SET_B_BY_ONE: assert property (
    @(posedge I_MCLK) disable iff (!I_RESET_N)
    (I_WR && sel_flags && flag_wr[1]) |=> flags_r[1]
  ) else $error("flag B not set by one write");

  AST_MODE_WRITE: assert property (
    @(posedge I_MCLK) disable iff (!I_RESET_N)
    (I_WR && sel_cfg) |=> (O_CMP_MODE == $past(I_WDATA[2:0]))
  ) else $error("mode field not written");

  AST_SWITCH_MODES: assert property (
    @(posedge I_MCLK) disable iff (!I_RESET_N)
    (mode != dcc_pkg::DCC_MODE_ONE_SWITCHED && mode != dcc_pkg::DCC_MODE_TWO_SWITCHED)
      |-> !(O_CMP_A_MINUS_SEL || O_CMP_B_MINUS_SEL)
  ) else $error("input switch active outside switched modes");

  AST_LINK_WRITE: assert property (
    @(posedge I_MCLK) disable iff (!I_RESET_N)
    (I_WR && sel_link) |=> (link_r == $past(I_WDATA[1:0]))
  ) else $error("timer link bits not written");

  AST_WAKE_NEEDS_SLEEP: assert property (
    @(posedge I_MCLK) disable iff (!I_RESET_N)
    O_WAKE |-> (I_SLEEP && (flags_r & enables_r) != 2'h0)
  ) else $error("wake without sleep and enabled flag");

  AST_RELATCH_ENDS: assert property (
    @(posedge I_MCLK) disable iff (!I_RESET_N)
    cfg_touch ##1 (cur == $past(cur)) |-> (mismatch == 2'h0)
  ) else $error("mismatch not ended by config access");

  AST_GATE_CMP: assert property (
    @(posedge I_MCLK) disable iff (!I_RESET_N)
    (link_r == 2'h0) |-> (O_TIMER_GATE == cur[1])
  ) else $error("gate not from comparator B");

  AST_IRQ_WHEN_ENABLED: assert property (
    @(posedge I_MCLK) disable iff (!I_RESET_N)
    (irq_ctrl_r == 2'h3 && (flags_r & enables_r) != 2'h0) |-> O_IRQ
  ) else $error("enabled flag without interrupt");

  AST_LINE_PORT_DATA: assert property (
    @(posedge I_MCLK) disable iff (!I_RESET_N)
    !routed |-> (O_LINE4_OUT == I_LINE4_DATA && O_LINE5_OUT == I_LINE5_DATA)
  ) else $error("port data lost outside routed mode");
endmodule

// *** verification/dcc_analog_model.sv ***
// Behavioural model of the two analog comparator cores and their input pins.
// Assumes pin voltages are 8-bit codes set by the bench; minus select from the block.
`timescale 1ns/1ps
module dcc_analog_model (
  // Analog levels
  input wire logic [7:0] i_a_plus,
  input wire logic [7:0] i_b_plus,
  input wire logic [31:0] i_lines,
  // Minus input selects
  input wire logic i_a_sel,
  input wire logic i_b_sel,
  // Raw results
  output logic o_a_raw,
  output logic o_b_raw
);
  wire logic [7:0] a_minus = i_a_sel ? i_lines[31:24] : i_lines[7:0];
  wire logic [7:0] b_minus = i_b_sel ? i_lines[23:16] : i_lines[15:8];
  assign o_a_raw = i_a_plus > a_minus;
  assign o_b_raw = i_b_plus > b_minus;
endmodule

// *** verification/dual_comparator_control_bench.sv ***
// Self-checking bench for the dual comparator control block.
// Assumes the analog model stands on the comparator side of the block.
`timescale 1ns/1ps
module dual_comparator_control_bench;
  logic clk, rst_n, wr, rd, a_raw, b_raw, tclk, gpin, slp, l4, l5;
  logic [7:0] addr, wdata, rdata, a_plus, b_plus, d;
  logic [2:0] mode;
  logic [3:0] apins;
  logic a_sel, b_sel, o4, o5, oe4, oe5, gate, irq, wake;
  logic [7:0] rst_adr [0:6] = '{8'h9C, 8'h97, 8'h0D, 8'h8D, 8'h0B, 8'h85, 8'h00};
  logic [7:0] rst_val [0:6] = '{8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};
  int mismatches, n_compared;

  dcc_top dut (.I_MCLK(clk), .I_RESET_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_CMP_A_RAW(a_raw), .I_CMP_B_RAW(b_raw), .O_CMP_MODE(mode),
    .O_CMP_A_MINUS_SEL(a_sel), .O_CMP_B_MINUS_SEL(b_sel), .O_ANALOG_PINS(apins),
    .I_LINE4_DATA(l4), .I_LINE5_DATA(l5), .O_LINE4_OUT(o4), .O_LINE5_OUT(o5),
    .O_LINE4_OE_N(oe4), .O_LINE5_OE_N(oe5), .I_TIMER_CLK(tclk), .I_GATE_PIN(gpin),
    .O_TIMER_GATE(gate), .I_SLEEP(slp), .O_IRQ(irq), .O_WAKE(wake));

  dcc_analog_model analog (.i_a_plus(a_plus), .i_b_plus(b_plus),
    .i_lines({8'd200, 8'd200, 8'd50, 8'd50}), .i_a_sel(a_sel), .i_b_sel(b_sel),
    .o_a_raw(a_raw), .o_b_raw(b_raw));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    test_done();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    {rst_n, wr, rd, tclk, gpin, slp, l4, l5} = '0;
    addr = 8'h00;
    wdata = 8'h00;
    a_plus = 8'd100;
    b_plus = 8'd10;
    do_reset();
    for (int i = 0; i < 7; i++) begin
      rd_reg(rst_adr[i]);
      chk(d, rst_val[i]);
    end
    for (int m = 0; m < 8; m++) begin
      wr_reg(8'h9C, 8'(m));
      chk({5'h0, mode}, 8'(m));
      chk({4'h0, apins}, (m == 7) ? 8'h00 : 8'h0F);
    end
    wr_reg(8'h9C, 8'h0A);
    chk({6'h0, a_sel, b_sel}, 8'h03);
    wr_reg(8'h9C, 8'h02);
    chk({6'h0, a_sel, b_sel}, 8'h00);
    wr_reg(8'h9C, 8'h09);
    chk({7'h0, a_sel}, 8'h01);
    wr_reg(8'h9C, 8'h01);
    chk({7'h0, a_sel}, 8'h00);
    for (int p = 0; p < 4; p++) begin
      wr_reg(8'h9C, 8'hC2 | 8'(p << 4));
      cyc(4);
      rd_reg(8'h9C);
      chk(d, {p[1], ~p[0], p[1], p[0], 4'h2});
    end
    // Change flags against the relatched results
    wr_reg(8'h9C, 8'h02);
    cyc(4);
    rd_reg(8'h9C);
    wr_reg(8'h0D, 8'h00);
    rd_reg(8'h0D);
    chk(d, 8'h00);
    @(posedge clk) a_plus <= 8'd10;
    cyc(5);
    rd_reg(8'h0D);
    chk(d, 8'h20);
    wr_reg(8'h0D, 8'h00);
    rd_reg(8'h0D);
    chk(d, 8'h20);
    rd_reg(8'h9C);
    wr_reg(8'h0D, 8'h00);
    rd_reg(8'h0D);
    chk(d, 8'h00);
    wr_reg(8'h0D, 8'h40);
    rd_reg(8'h0D);
    chk(d, 8'h40);
    wr_reg(8'h8D, 8'h40);
    wr_reg(8'h0B, 8'h40);
    chk({7'h0, irq}, 8'h00);
    wr_reg(8'h0B, 8'hC0);
    chk({7'h0, irq}, 8'h01);
    @(posedge clk) slp <= 1'b1;
    @(negedge clk) chk({7'h0, wake}, 8'h01);
    @(posedge clk) slp <= 1'b0;
    wr_reg(8'h8D, 8'h00);
    chk({7'h0, irq}, 8'h00);
    rd_reg(8'h0D);
    chk(d, 8'h40);
    // Routed outputs on lines 4 and 5
    wr_reg(8'h85, 8'hCF);
    wr_reg(8'h9C, 8'h16);
    cyc(2);
    chk({6'h0, oe5, oe4}, 8'h00);
    chk({7'h0, o4}, {7'h0, ~a_raw});
    chk({7'h0, o5}, {7'h0, b_raw});
    wr_reg(8'h85, 8'hFF);
    chk({6'h0, oe5, oe4}, 8'h03);
    // Timer gate source and falling-edge latch
    wr_reg(8'h9C, 8'h02);
    @(posedge clk) b_plus <= 8'd100;
    wr_reg(8'h97, 8'h00);
    cyc(5);
    chk({7'h0, gate}, 8'h01);
    @(posedge clk) b_plus <= 8'd10;
    cyc(5);
    chk({7'h0, gate}, 8'h00);
    @(posedge clk) tclk <= 1'b1;
    wr_reg(8'h97, 8'h01);
    @(posedge clk) b_plus <= 8'd100;
    cyc(8);
    chk({7'h0, gate}, 8'h00);
    @(posedge clk) tclk <= 1'b0;
    cyc(6);
    chk({7'h0, gate}, 8'h01);
    wr_reg(8'h97, 8'h02);
    @(posedge clk) gpin <= 1'b1;
    cyc(5);
    chk({7'h0, gate}, 8'h01);
    @(posedge clk) gpin <= 1'b0;
    cyc(5);
    chk({7'h0, gate}, 8'h00);
    // Reset in mid-run
    do_reset();
    rd_reg(8'h9C);
    chk(d, 8'h00);
    rd_reg(8'h97);
    chk(d, 8'h02);
    test_done();
  end
endmodule
